// ==== logic/adc_conversion_mode_sequencer.sv ====
// Conversion mode sequencer for an eight-channel converter.
// Assumes control bits come from software logic on sys_clk, the core
// answers on sys_clk, and only the external trigger is asynchronous.
//
// How it works
// - Setting start flag begins conversion
// - Clearing start flag aborts and stops
// - One-shot converts selected channel once
// - One-shot and single sweep self-clear flag
// - External trigger keeps flag set at end
// - One-shot completion raises interrupt request
// - Repeat converts one channel forever, no interrupt
// - Results readable any time while converting
// - Each result lands in its channel register
// - Single sweep converts each group channel once
// - Sweep groups: 0-1, 0-3, 0-5, 0-7
// - Repeat sweep 0 loops until flag cleared

// Mode codes and reset values; guarded, so a second include is harmless
`include "adc_seq_cfg.svh"

module adc_conversion_mode_sequencer (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire adc_seq_pkg::ctrl_t ctrl,
    input wire logic ext_trig,
    input wire adc_seq_pkg::core_ans_t core_ans,
    output logic start_flag,
    output logic conv_req,
    output adc_seq_pkg::chan_t mux_chan,
    output logic conv_irq,
    output logic busy,
    output adc_seq_pkg::result_bank_t results
);

    // Registered state and its next value
    adc_seq_pkg::seq_regs_t s_ff;
    adc_seq_pkg::seq_regs_t nxt_s;

    // Highest channel of a sweep group: 1, 3, 5 or 7
    function automatic adc_seq_pkg::chan_t last_chan(input logic [1:0] grp);
        last_chan = {grp, 1'b1};
    endfunction : last_chan

    // Sweep modes start at channel zero
    function automatic logic is_sweep(input logic [1:0] mode);
        is_sweep = (mode == `ADC_MODE_SSWEEP) || (mode == `ADC_MODE_RSWEEP0);
    endfunction : is_sweep

    // Decoded helpers
    logic trig_rise;  // Synchronised trigger rising edge
    logic at_last;    // Current channel ends the sweep group
    logic self_stop;  // Mode that ends by itself

    assign trig_rise = s_ff.trig_s2 & ~s_ff.trig_prev;
    assign at_last = (s_ff.chan == last_chan(ctrl.sweep_grp));
    assign self_stop = (ctrl.mode == `ADC_MODE_ONESHOT) ||
                       (ctrl.mode == `ADC_MODE_SSWEEP && at_last);

    // Next-state logic for the whole sequencer
    always_comb begin
        nxt_s = s_ff;
        nxt_s.irq = 1'b0;
        // Trigger pin passes two flops before any use
        nxt_s.trig_s1 = ext_trig;
        nxt_s.trig_s2 = s_ff.trig_s1;
        nxt_s.trig_prev = s_ff.trig_s2;
        // Software write of 1 to the flag
        if (ctrl.start_set) begin
            nxt_s.flag = 1'b1;
        end
        case (s_ff.st)
            adc_seq_pkg::ST_IDLE: begin
                // Flag seen set: pick first channel and go
                if (s_ff.flag) begin
                    // Sweeps begin at zero, others use the selection
                    nxt_s.chan = is_sweep(ctrl.mode) ? `ADC_CHAN_RST : ctrl.chan_sel;
                    if (ctrl.ext_sel) begin
                        nxt_s.st = adc_seq_pkg::ST_WAIT;
                    end else begin
                        nxt_s.st = adc_seq_pkg::ST_CONV;
                        nxt_s.req = 1'b1;
                    end
                end
            end
            adc_seq_pkg::ST_WAIT: begin
                // Armed; the trigger edge starts the conversion
                if (trig_rise) begin
                    nxt_s.st = adc_seq_pkg::ST_CONV;
                    nxt_s.req = 1'b1;
                end
            end
            adc_seq_pkg::ST_CONV: begin
                // Request held high until the core answers
                if (core_ans.done) begin
                    nxt_s.res[s_ff.chan] = core_ans.data;
                    if (self_stop) begin
                        // End of one-shot or last sweep channel
                        nxt_s.st = adc_seq_pkg::ST_IDLE;
                        nxt_s.req = 1'b0;
                        // With external trigger the flag stays, rearming
                        if (!ctrl.ext_sel && !ctrl.start_set) begin
                            nxt_s.flag = 1'b0;
                        end
                        nxt_s.irq = (ctrl.mode == `ADC_MODE_ONESHOT);
                    end else if (ctrl.mode == `ADC_MODE_REPEAT) begin
                        // Same channel again, no interrupt
                        nxt_s.chan = s_ff.chan;
                    end else if (at_last) begin
                        // Repeat sweep 0 wraps to the first channel
                        nxt_s.chan = `ADC_CHAN_RST;
                    end else begin
                        // Next channel of the sweep
                        nxt_s.chan = 3'(s_ff.chan + 3'h1);
                    end
                end
            end
            default: begin
                // Illegal code: recover to idle
                nxt_s.st = adc_seq_pkg::ST_IDLE;
                nxt_s.req = 1'b0;
            end
        endcase
        // Writing 0 aborts everything; beats a same-cycle set
        if (ctrl.start_clr) begin
            nxt_s.flag = 1'b0;
            nxt_s.st = adc_seq_pkg::ST_IDLE;
            nxt_s.req = 1'b0;
            nxt_s.irq = 1'b0;
        end
        // Busy kept in a flop so the output has no decode glitch
        nxt_s.busy = (nxt_s.st != adc_seq_pkg::ST_IDLE);
    end

    // State register; clock enable freezes everything
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= '0;
            s_ff.st <= adc_seq_pkg::ST_IDLE;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state flops
    assign start_flag = s_ff.flag;
    assign conv_req = s_ff.req;
    assign mux_chan = s_ff.chan;
    assign conv_irq = s_ff.irq;
    assign busy = s_ff.busy;
    // Result bank never blocked by ongoing conversions
    assign results = s_ff.res;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Conditions shared by several checks
    logic conv_end;
    assign conv_end = ce && s_ff.st == adc_seq_pkg::ST_CONV && core_ans.done && !ctrl.start_clr;

    a_start_kicks: assert property (
        ce && s_ff.st == adc_seq_pkg::ST_IDLE && s_ff.flag && !ctrl.ext_sel && !ctrl.start_clr
        |=> s_ff.req && s_ff.st == adc_seq_pkg::ST_CONV)
        else $error("start flag did not launch a conversion");
    a_clear_aborts: assert property (
        ce && ctrl.start_clr |=> !s_ff.flag && !s_ff.req && s_ff.st == adc_seq_pkg::ST_IDLE)
        else $error("clearing start flag did not abort");
    a_oneshot_chan: assert property (
        ce && s_ff.st == adc_seq_pkg::ST_IDLE && s_ff.flag && ctrl.mode == `ADC_MODE_ONESHOT && !ctrl.start_clr
        |=> s_ff.chan == $past(ctrl.chan_sel))
        else $error("one-shot channel not the selected one");
    a_auto_clear: assert property (
        conv_end && self_stop && !ctrl.ext_sel && !ctrl.start_set |=> !s_ff.flag ##1 !s_ff.req)
        else $error("start flag not self-cleared");
    a_ext_keeps_flag: assert property (
        conv_end && self_stop && ctrl.ext_sel && s_ff.flag |=> s_ff.flag)
        else $error("flag cleared with external trigger");
    a_oneshot_irq: assert property (
        conv_end && ctrl.mode == `ADC_MODE_ONESHOT |=> s_ff.irq && s_ff.st == adc_seq_pkg::ST_IDLE)
        else $error("one-shot interrupt missing");
    a_repeat_hold: assert property (
        conv_end && ctrl.mode == `ADC_MODE_REPEAT |=> s_ff.req && !s_ff.irq && s_ff.chan == $past(s_ff.chan))
        else $error("repeat mode did not continue quietly");
    a_result_store: assert property (
        conv_end |=> s_ff.res[$past(s_ff.chan)] == $past(core_ans.data))
        else $error("result not stored by channel");
    a_sweep_step: assert property (
        conv_end && is_sweep(ctrl.mode) && !at_last |=> s_ff.chan == 3'($past(s_ff.chan) + 3'h1))
        else $error("sweep did not step to next channel");
    a_sweep_end: assert property (
        conv_end && ctrl.mode == `ADC_MODE_SSWEEP && at_last
        |=> s_ff.st == adc_seq_pkg::ST_IDLE && !s_ff.irq && !s_ff.req)
        else $error("single sweep did not end at last channel");
    a_sweep_wrap: assert property (
        conv_end && ctrl.mode == `ADC_MODE_RSWEEP0 && at_last |=> s_ff.chan == 3'h0 && s_ff.req)
        else $error("repeat sweep did not wrap to zero");
    // Low enable must hold every bit, synchroniser included
    a_ce_freeze_all: assert property (
        !ce |=> s_ff == $past(s_ff))
        else $error("state moved while clock enable low");
    // Interrupt is a single-cycle pulse
    a_irq_pulse: assert property (
        ce && s_ff.irq |=> !s_ff.irq)
        else $error("interrupt pulse longer than one cycle");
    // Armed state waits quietly for the trigger edge
    a_wait_armed: assert property (
        ce && s_ff.st == adc_seq_pkg::ST_WAIT && !trig_rise && !ctrl.start_clr
        |=> s_ff.st == adc_seq_pkg::ST_WAIT && !s_ff.req)
        else $error("armed sequencer left wait without trigger");
    a_trig_launch: assert property (
        ce && s_ff.st == adc_seq_pkg::ST_WAIT && trig_rise && !ctrl.start_clr
        |=> s_ff.st == adc_seq_pkg::ST_CONV && s_ff.req)
        else $error("trigger edge did not launch a conversion");
    // Both sweeps begin at the lowest channel
    a_sweep_first: assert property (
        ce && s_ff.st == adc_seq_pkg::ST_IDLE && s_ff.flag && is_sweep(ctrl.mode) && !ctrl.start_clr
        |=> s_ff.chan == 3'h0)
        else $error("sweep did not begin at channel zero");

    c_oneshot_done: cover property (conv_end && ctrl.mode == `ADC_MODE_ONESHOT);
    c_sweep_end: cover property (conv_end && ctrl.mode == `ADC_MODE_SSWEEP && at_last);
    c_repeat_run: cover property (conv_end && ctrl.mode == `ADC_MODE_REPEAT);
    c_sweep_wrap: cover property (conv_end && ctrl.mode == `ADC_MODE_RSWEEP0 && at_last);
    c_trig_start: cover property (ce && s_ff.st == adc_seq_pkg::ST_WAIT && trig_rise);

endmodule : adc_conversion_mode_sequencer

// ==== inc/adc_seq_cfg.svh ====
// Constants of the conversion sequencer: mode codes, widths, reset values.
// Guarded, so repeated includes in one compile unit are harmless; included by its bare name.
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Operating mode codes on the mode select input
`define ADC_MODE_ONESHOT 2'h0
`define ADC_MODE_REPEAT 2'h1
`define ADC_MODE_SSWEEP 2'h2
`define ADC_MODE_RSWEEP0 2'h3

// Channel count and result width
`define ADC_NUM_CHAN 8
`define ADC_CHAN_W 3
`define ADC_RES_W 10

// Reset values
`define ADC_CHAN_RST 3'h0
`define ADC_RES_RST 10'h000

`endif

// ==== inc/adc_seq_pkg.sv ====
// Types shared by the conversion sequencer.
// Assumes adc_seq_cfg.svh is on the include path.
`include "adc_seq_cfg.svh"

package adc_seq_pkg;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } seq_state_t;

    typedef logic [`ADC_CHAN_W-1:0] chan_t;
    typedef logic [`ADC_RES_W-1:0] result_t;
    typedef result_t [`ADC_NUM_CHAN-1:0] result_bank_t;

    // Software control bits, all same clock domain
    typedef struct packed {
        logic start_set;   // Pulse: write 1 to start flag
        logic start_clr;   // Pulse: write 0 to start flag
        logic [1:0] mode;  // Operating mode
        chan_t chan_sel;   // Single-channel selection
        logic [1:0] sweep_grp; // Sweep group selection
        logic ext_sel;     // External trigger selected
    } ctrl_t;

    // Converter core answer
    typedef struct packed {
        logic done;        // Pulse: conversion finished
        result_t data;     // Result valid with done
    } core_ans_t;

    // Whole state of the sequencer
    typedef struct packed {
        seq_state_t st;
        logic flag;        // Conversion start flag
        logic req;         // Conversion request to core
        chan_t chan;       // Channel on the multiplexer
        logic irq;         // Completion interrupt pulse
        logic busy;        // Registered copy of state != idle
        logic trig_s1;     // Trigger synchroniser, first stage
        logic trig_s2;     // Trigger synchroniser, second stage
        logic trig_prev;   // Last synchronised trigger level
        result_bank_t res; // One result register per channel
    } seq_regs_t;

endpackage : adc_seq_pkg

// ==== tb/core_model.sv ====
// Behavioural converter core facing the sequencer.
// Assumes a level request and a one-cycle done pulse on sys_clk.
module core_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic conv_req,
    input wire adc_seq_pkg::chan_t mux_chan,
    input wire logic slow,
    output adc_seq_pkg::core_ans_t core_ans
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt; // Cycles into this conversion
    logic [6:0] seq; // Sample count, keeps each result unique
    // One done per request; data toggles while stale so it never looks valid
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            seq <= 7'h00;
            core_ans <= '0;
        end else if (!conv_req || core_ans.done) begin
            cnt <= 4'h0;
            core_ans.done <= 1'b0;
            core_ans.data <= ~core_ans.data;
        end else if (cnt == (slow ? 4'h6 : 4'h2)) begin
            core_ans <= {1'b1, mux_chan, seq};
            seq <= seq + 7'h01;
        end else begin
            cnt <= cnt + 4'h1;
            core_ans.data <= ~core_ans.data;
        end
    end
endmodule : core_model

// ==== tb/testbench.sv ====
// Self-checking bench for the conversion mode sequencer.
// Assumes core_model and the design package are compiled first.
`include "adc_seq_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1; // Dropped once while armed to prove the freeze
    adc_seq_pkg::ctrl_t ctrl = '0;
    logic ext_trig = 1'b0;
    logic slow = 1'b0; // Core latency, random per test
    adc_seq_pkg::core_ans_t core_ans;
    logic start_flag, conv_req, conv_irq, busy, pend = 1'b0;
    adc_seq_pkg::chan_t mux_chan, pch, exp_q[$];
    adc_seq_pkg::result_bank_t results;
    adc_seq_pkg::result_t pdata;
    int err_total = 0;
    int cmp_count = 0;
    int irq_n = 0;
    int irq0 = 0;
    int seed = 32'h182a;
    always #4 sys_clk = ~sys_clk;
    adc_conversion_mode_sequencer dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .ctrl(ctrl), .ext_trig(ext_trig),
        .core_ans(core_ans), .start_flag(start_flag), .conv_req(conv_req), .mux_chan(mux_chan),
        .conv_irq(conv_irq), .busy(busy), .results(results));
    core_model core_u (.sys_clk(sys_clk), .rst_b(rst_b), .conv_req(conv_req), .mux_chan(mux_chan),
        .slow(slow), .core_ans(core_ans));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // Watcher: each accepted done takes the oldest expected channel
    always @(posedge sys_clk) begin
        if (pend) begin
            check(results[pch], pdata);
        end
        pend <= 1'b0;
        if (rst_b && ce && conv_req && core_ans.done) begin
            if (exp_q.size() == 0) begin
                check(16'hffff, mux_chan); // Conversion nobody asked for
            end else begin
                check(mux_chan, exp_q.pop_front());
            end
            pend <= 1'b1;
            pch <= mux_chan;
            pdata <= core_ans.data;
        end
        if (conv_irq) begin
            irq_n++;
        end
    end
    // Control changed only while idle, channel always reloaded
    task automatic setup(input logic [1:0] m, input adc_seq_pkg::chan_t ch, input logic [1:0] g, input logic x);
        @(posedge sys_clk);
        ctrl.mode <= m;
        ctrl.chan_sel <= ch;
        ctrl.sweep_grp <= g;
        ctrl.ext_sel <= x;
        slow <= 1'($random(seed));
        irq0 = irq_n;
    endtask : setup
    task automatic sw(input logic s, input logic c);
        @(posedge sys_clk);
        ctrl.start_set <= s;
        ctrl.start_clr <= c;
        @(posedge sys_clk);
        ctrl.start_set <= 1'b0;
        ctrl.start_clr <= 1'b0;
    endtask : sw
    // Bounded wait for the queue to drain and, if asked, for idle
    task automatic wait_end(input logic idle);
        for (int i = 0; i < 500; i++) begin
            @(negedge sys_clk);
            if (exp_q.size() == 0 && !(idle && busy)) begin
                repeat (idle ? 2 : 0) @(negedge sys_clk);
                return;
            end
        end
        err_total++;
        report_and_stop();
    endtask : wait_end
    task automatic stop_chk();
        sw(1'b0, 1'b1);
        @(negedge sys_clk);
        check(start_flag, 1'b0);
        check({busy, conv_req}, 2'h0);
    endtask : stop_chk
    initial begin
        adc_seq_pkg::chan_t ch;
        int g;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        ch = 3'($random(seed));
        // One-shot on every channel from a random start
        for (int c = 0; c < 8; c++) begin
            setup(`ADC_MODE_ONESHOT, ch, 2'h0, 1'b0);
            exp_q.push_back(ch);
            sw(1'b1, 1'b0);
            wait_end(1'b1);
            check(start_flag, 1'b0);
            check(irq_n - irq0, 1);
            ch = ch + 3'h1;
        end
        $display("one-shot test ended");
        setup(`ADC_MODE_REPEAT, ch, 2'h0, 1'b0);
        repeat (4) exp_q.push_back(ch);
        sw(1'b1, 1'b0);
        wait_end(1'b0);
        stop_chk();
        check(irq_n - irq0, 0);
        $display("repeat test ended");
        // Every sweep group, once each
        for (g = 0; g < 4; g++) begin
            setup(`ADC_MODE_SSWEEP, ch, 2'(g), 1'b0);
            for (int k = 0; k <= 2 * g + 1; k++) exp_q.push_back(3'(k));
            sw(1'b1, 1'b0);
            wait_end(1'b1);
            check(start_flag, 1'b0);
        end
        $display("single sweep test ended");
        g = 32'($random(seed)) & 3;
        setup(`ADC_MODE_RSWEEP0, ch, 2'(g), 1'b0);
        for (int k = 0; k < 4 * g + 5; k++) exp_q.push_back(3'(k % (2 * g + 2)));
        sw(1'b1, 1'b0);
        wait_end(1'b0);
        stop_chk();
        $display("repeat sweep test ended");
        // External trigger: armed wait, flag kept at the end
        setup(`ADC_MODE_ONESHOT, ch, 2'h0, 1'b1);
        sw(1'b1, 1'b0);
        repeat (4) @(negedge sys_clk);
        check({busy, conv_req}, 2'h2);
        // Frozen clock enable: an abort written now must be lost
        @(posedge sys_clk);
        ce <= 1'b0;
        sw(1'b0, 1'b1);
        @(negedge sys_clk);
        check({start_flag, busy}, 2'h3);
        @(posedge sys_clk);
        ce <= 1'b1;
        exp_q.push_back(ch);
        @(posedge sys_clk);
        ext_trig <= 1'b1;
        wait_end(1'b0);
        @(posedge sys_clk);
        ext_trig <= 1'b0;
        @(negedge sys_clk);
        check(start_flag, 1'b1);
        check(irq_n - irq0, 1);
        stop_chk();
        $display("trigger test ended");
        // Reset in mid-run, then a fresh one-shot on the same channel
        setup(`ADC_MODE_REPEAT, ch, 2'h0, 1'b0);
        sw(1'b1, 1'b0);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(negedge sys_clk);
        check({start_flag, conv_req, busy, conv_irq}, 4'h0);
        check({mux_chan, results[ch]}, 13'h0000);
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        setup(`ADC_MODE_ONESHOT, ch, 2'h0, 1'b0);
        exp_q.push_back(ch);
        sw(1'b1, 1'b0);
        wait_end(1'b1);
        check(start_flag, 1'b0);
        check(irq_n - irq0, 1);
        $display("reset test ended");
        report_and_stop();
    end
endmodule : testbench
